// [core/bcs_sequencer.v]
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "bcs_map.vh"

module bcs_sequencer #(
	parameter [17:0] MAIN_HOLD_CYC = `BCS_MAIN_HOLD_CYC,
	parameter [17:0] IOP_HOLD_CYC  = `BCS_IOP_HOLD_CYC,
	parameter [17:0] BUZZ_HALF_CYC = `BCS_BUZZ_HALF_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        standby_3v3_good,
	input  wire        rail_1v8_good,
	input  wire        rail_1v5_good,
	input  wire        rail_1v35_good,
	input  wire        rail_1v2_good,
	input  wire        front_system_reset_n,
	input  wire        iop_power_good,
	input  wire        power_fail_delay,
	input  wire        power_fail_done,
	input  wire        audio_trigger,
	input  wire        cache_dirty,
	input  wire        alarm_color_select,
	input  wire        critical_alarm,
	input  wire        major_alarm,
	input  wire [2:0]  drive_present,
	input  wire [2:0]  drive_activity,
	input  wire [2:0]  drive_fault,
	output reg  [3:0]  rail_enable,
	output reg         main_reset_n,
	output reg         iop_reset_n,
	output reg         buzzer,
	output reg         battery_backup_enable,
	output reg         battery_strobe,
	output reg         critical_red,
	output reg         critical_yellow,
	output reg         major_red,
	output reg         major_yellow,
	output reg         drive_led_green,
	output reg         drive_led_amber,
	output reg         dimm_cke_hold,
	output wire        array_select
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] ST_OFF   = 4'h0;
	localparam [3:0] ST_1V8   = 4'h1;
	localparam [3:0] ST_1V5   = 4'h2;
	localparam [3:0] ST_1V35  = 4'h3;
	localparam [3:0] ST_1V2   = 4'h4;
	localparam [3:0] ST_MAIN  = 4'h5;
	localparam [3:0] ST_IOP   = 4'h6;
	localparam [3:0] ST_RUN   = 4'h7;

	localparam [17:0] STROBE_CYC = `BCS_STROBE_CYC;

	function [17:0] tmr_next;
		input [17:0] t;
		begin
			tmr_next = (t == 18'h00000) ? 18'h00000 : t - 18'h00001;
		end
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire [9:0] async_in = {cache_dirty, audio_trigger, power_fail_done, power_fail_delay,
		iop_power_good, front_system_reset_n, rail_1v2_good, rail_1v35_good,
		rail_1v5_good, rail_1v8_good};
	reg  [9:0] sync1_q;
	reg  [9:0] sync2_q;
	reg        stby1_q;
	reg        stby2_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 10'h000;
			sync2_q <= 10'h000;
			stby1_q <= 1'b0;
			stby2_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
			stby1_q <= standby_3v3_good;
			stby2_q <= stby1_q;
		end
	end

	// Active-high goods, front reset taken as server 3.3 V good
	wire [3:0] rail_good_s = sync2_q[3:0];
	wire       srv_good_s  = sync2_q[4];
	wire       iop_good_s  = sync2_q[5];
	wire       pf_delay_s  = sync2_q[6];
	wire       pf_done_s   = sync2_q[7];
	wire       trig_s      = sync2_q[8];
	wire       dirty_s     = sync2_q[9];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [31:0] ctrl_q;
	wire        hit_ctrl = (paddr == `BCS_CTRL_OFF);
	wire        hit_stat = (paddr == `BCS_STAT_OFF);
	wire        apb_acc  = psel & penable;

	assign pready       = 1'b1;
	assign pslverr      = apb_acc & ~(hit_ctrl | hit_stat);
	assign array_select = ctrl_q[`BCS_CTRL_ARRAY];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= `BCS_CTRL_RST;
		else if (ce && apb_acc && pwrite && hit_ctrl)
			ctrl_q <= {30'h00000000, pwdata[1:0]};
	end

	// ----------------------------------------
	// Power and reset sequencer
	// ----------------------------------------
	reg  [3:0]  state_q;
	reg  [3:0]  state_d;
	reg  [17:0] tmr_q;
	reg  [17:0] tmr_d;
	wire        base_ok = stby2_q & srv_good_s & ctrl_q[`BCS_CTRL_SEQ_EN];

	always @* begin
		state_d = state_q;
		tmr_d   = tmr_next(tmr_q);
		case (state_q)
			ST_OFF:
				if (base_ok)
					state_d = ST_1V8;
			ST_1V8:
				if (rail_good_s[0])
					state_d = ST_1V5;
			ST_1V5:
				if (rail_good_s[1])
					state_d = ST_1V35;
			ST_1V35:
				if (rail_good_s[2])
					state_d = ST_1V2;
			ST_1V2:
				if (rail_good_s[3]) begin
					state_d = ST_MAIN;
					tmr_d   = MAIN_HOLD_CYC;
				end
			ST_MAIN:
				if (!iop_good_s)
					tmr_d = MAIN_HOLD_CYC;
				else if (tmr_q == 18'h00000) begin
					state_d = ST_IOP;
					tmr_d   = IOP_HOLD_CYC;
				end
			ST_IOP:
				if (tmr_q == 18'h00000)
					state_d = ST_RUN;
			ST_RUN:
				state_d = ST_RUN;
			default:
				state_d = ST_OFF;
		endcase
		// Lost standby/server good drops to off in any state, rail good past ST_1V2, iop good past ST_MAIN; every reset asserted
		if (state_q != ST_OFF) begin
			if (!base_ok || (state_q > ST_1V2 && rail_good_s != 4'hf) ||
				(state_q > ST_MAIN && !iop_good_s))
				state_d = ST_OFF;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= ST_OFF;
			tmr_q        <= 18'h00000;
			rail_enable  <= 4'h0;
			main_reset_n <= 1'b0;
			iop_reset_n  <= 1'b0;
		end else if (ce) begin
			state_q      <= state_d;
			tmr_q        <= tmr_d;
			rail_enable  <= {state_d >= ST_1V2, state_d >= ST_1V35,
				state_d >= ST_1V5, state_d >= ST_1V8};
			main_reset_n <= (state_d >= ST_IOP);
			iop_reset_n  <= (state_d == ST_RUN);
		end
	end

	// ----------------------------------------
	// Buzzer tone
	// ----------------------------------------
	reg [17:0] buzz_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buzz_q <= 18'h00000;
			buzzer <= 1'b0;
		end else if (ce) begin
			if (!trig_s) begin
				buzz_q <= 18'h00000;
				buzzer <= 1'b0;
			end else if (buzz_q == 18'h00000) begin
				buzz_q <= BUZZ_HALF_CYC - 18'h00001;
				buzzer <= ~buzzer;
			end else begin
				buzz_q <= buzz_q - 18'h00001;
			end
		end
	end

	// ----------------------------------------
	// Battery backup control
	// ----------------------------------------
	reg [17:0] strobe_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			battery_backup_enable <= 1'b0;
			battery_strobe        <= 1'b0;
			strobe_q              <= 18'h00000;
		end else if (ce) begin
			battery_backup_enable <= dirty_s;
			if (dirty_s != battery_backup_enable) begin
				strobe_q       <= STROBE_CYC;
				battery_strobe <= 1'b1;
			end else begin
				strobe_q       <= tmr_next(strobe_q);
				battery_strobe <= (strobe_q > 18'h00001);
			end
		end
	end

	// ----------------------------------------
	// DIMM self-refresh hold
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dimm_cke_hold <= 1'b0;
		else if (ce) begin
			if (!iop_good_s && pf_delay_s && pf_done_s)
				dimm_cke_hold <= 1'b1;
			else if (iop_good_s && stby2_q && rail_good_s[0])
				dimm_cke_hold <= 1'b0;
		end
	end

	// ----------------------------------------
	// Alarm and drive LEDs
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			critical_red    <= 1'b0;
			critical_yellow <= 1'b0;
			major_red       <= 1'b0;
			major_yellow    <= 1'b0;
			drive_led_green <= 1'b0;
			drive_led_amber <= 1'b0;
		end else if (ce) begin
			critical_red    <= critical_alarm & alarm_color_select;
			critical_yellow <= critical_alarm & ~alarm_color_select;
			major_red       <= major_alarm & alarm_color_select;
			major_yellow    <= major_alarm & ~alarm_color_select;
			drive_led_amber <= |(drive_present & drive_fault);
			drive_led_green <= |(drive_present & drive_activity) &
				~|(drive_present & drive_fault);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (ce && psel && !penable && !pwrite) begin
			if (paddr == `BCS_CTRL_OFF)
				prdata <= ctrl_q;
			else if (paddr == `BCS_STAT_OFF)
				prdata <= {16'h0000, battery_backup_enable, dimm_cke_hold, iop_reset_n,
					main_reset_n, iop_good_s, srv_good_s, stby2_q, rail_good_s,
					1'b0, state_q};
			else
				prdata <= 32'h00000000;
		end
	end

endmodule

// [pkg/bcs_map.vh]
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define BCS_CLK_HZ          100000000
`define BCS_MAIN_HOLD_US    1000
`define BCS_IOP_HOLD_US     1500
`define BCS_BUZZ_HZ         2400
`define BCS_STROBE_NS       1000
// Cycle counts at the clock rate above, sized to the timer width
`define BCS_MAIN_HOLD_CYC   18'h186a0
`define BCS_IOP_HOLD_CYC    18'h249f0
`define BCS_BUZZ_HALF_CYC   18'h05161
`define BCS_STROBE_CYC      18'h00064
`define BCS_TMR_W           18

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCS_CTRL_OFF        12'h000
`define BCS_STAT_OFF        12'h004

// ----------------------------------------
// Control fields
// ----------------------------------------
`define BCS_CTRL_SEQ_EN     0
`define BCS_CTRL_ARRAY      1
`define BCS_CTRL_RST        32'h0000_0001

// ----------------------------------------
// Status fields
// ----------------------------------------
`define BCS_STAT_STATE_LO   0
`define BCS_STAT_GOOD_LO    5
`define BCS_STAT_MAIN_RST   12
`define BCS_STAT_IOP_RST    13
`define BCS_STAT_CKE_HOLD   14
`define BCS_STAT_BBE        15

`endif

// [tb/bcs_seq_chk.sv]
`timescale 1ns/10ps
module bcs_seq_chk #(
	parameter [17:0] MAIN_HOLD_CYC = 18'h186a0,
	parameter [17:0] IOP_HOLD_CYC  = 18'h249f0
) (
	input wire       pclk,
	input wire       presetn,
	input wire       front_system_reset_n,
	input wire       iop_power_good,
	input wire       rail_1v8_good,
	input wire       audio_trigger,
	input wire       alarm_color_select,
	input wire       critical_alarm,
	input wire [2:0] drive_fault,
	input wire [2:0] drive_present,
	input wire [3:0] rail_enable,
	input wire       main_reset_n,
	input wire       iop_reset_n,
	input wire       buzzer,
	input wire       battery_backup_enable,
	input wire       battery_strobe,
	input wire       critical_red,
	input wire       critical_yellow,
	input wire       drive_led_amber,
	input wire       drive_led_green
);
	// ----
	// Hold counters
	// ----
	logic [17:0] good_cnt_q;
	logic [17:0] rel_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_cnt_q <= 18'h0;
			rel_cnt_q  <= 18'h0;
		end else begin
			good_cnt_q <= !iop_power_good ? 18'h0 : good_cnt_q + {17'h0, ~&good_cnt_q};
			rel_cnt_q  <= !main_reset_n ? 18'h0 : rel_cnt_q + {17'h0, ~&rel_cnt_q};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rail_order_a: assert property (rail_enable inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
		else $error("rail enables out of order");
	rail_wait_a: assert property ($rose(rail_enable[1]) |-> $past(rail_1v8_good, 3))
		else $error("second rail before first good");
	main_hold_a: assert property ($rose(main_reset_n) |-> good_cnt_q >= MAIN_HOLD_CYC)
		else $error("main reset released early");
	iop_hold_a: assert property ($rose(iop_reset_n) |-> rel_cnt_q + 18'h1 >= IOP_HOLD_CYC)
		else $error("processor reset released early");
	srv_loss_a: assert property (!front_system_reset_n [*5] |-> !main_reset_n && !iop_reset_n)
		else $error("resets not asserted on server loss");
	buzz_idle_a: assert property (!audio_trigger [*4] |-> !buzzer)
		else $error("buzzer active without trigger");
	strobe_start_a: assert property ($changed(battery_backup_enable) |-> ##[0:1] battery_strobe)
		else $error("no strobe on backup change");
	alarm_red_a: assert property ((critical_alarm && alarm_color_select) [*3] |->
		critical_red && !critical_yellow) else $error("alarm not red");
	drive_fault_a: assert property ((|(drive_present & drive_fault)) [*3] |->
		drive_led_amber && !drive_led_green)
		else $error("fault not amber");
	main_up_c: cover property ($rose(main_reset_n));
	iop_up_c: cover property ($rose(iop_reset_n));
	strobe_c: cover property ($rose(battery_strobe));
endmodule

bind bcs_sequencer bcs_seq_chk #(
	.MAIN_HOLD_CYC(MAIN_HOLD_CYC),
	.IOP_HOLD_CYC (IOP_HOLD_CYC)
) chk_u (.*);

// [tb/bcs_board_model.sv]
`timescale 1ns/10ps
module bcs_board_model (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       stby_on,
	input  wire       srv_on,
	input  wire       iop_ok,
	input  wire [3:0] rail_enable,
	output logic      standby_3v3_good,
	output logic      rail_1v8_good,
	output logic      rail_1v5_good,
	output logic      rail_1v35_good,
	output logic      rail_1v2_good,
	output logic      front_system_reset_n,
	output logic      iop_power_good
);
	// Rails report good a cycle after enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{rail_1v2_good, rail_1v35_good, rail_1v5_good, rail_1v8_good} <= 4'h0;
			iop_power_good <= 1'b0;
		end else begin
			{rail_1v2_good, rail_1v35_good, rail_1v5_good, rail_1v8_good} <= rail_enable;
			iop_power_good <= rail_1v2_good & iop_ok;
		end
	end
	assign standby_3v3_good     = stby_on;
	assign front_system_reset_n = srv_on;
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
	localparam int BUZZ = 5;
	logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic        stby_on = 1'b0, srv_on = 1'b0, iop_ok = 1'b0, audio_trigger = 1'b0;
	logic        power_fail_delay = 1'b0, power_fail_done = 1'b0, cache_dirty = 1'b0;
	logic        alarm_color_select = 1'b0, critical_alarm = 1'b0, major_alarm = 1'b0;
	logic [2:0]  drive_present = 3'h7, drive_activity = 3'h0, drive_fault = 3'h0;
	wire         pready, pslverr, main_reset_n, iop_reset_n, buzzer, battery_backup_enable;
	wire         battery_strobe, critical_red, critical_yellow, major_red, major_yellow;
	wire         drive_led_green, drive_led_amber, dimm_cke_hold, array_select;
	wire         standby_3v3_good, rail_1v8_good, rail_1v5_good, rail_1v35_good;
	wire         rail_1v2_good, front_system_reset_n, iop_power_good;
	wire  [31:0] prdata;
	wire  [3:0]  rail_enable;
	int          error_cnt = 0, num_checks = 0, n, k;

	always #5 pclk = ~pclk;

	bcs_sequencer #(.MAIN_HOLD_CYC(18'h14), .IOP_HOLD_CYC(18'h1e), .BUZZ_HALF_CYC(18'h5)) dut_u (.*);
	bcs_board_model model_u (.*);

	// ----
	// Tasks
	// ----
	task automatic end_of_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tmo(input int c, input int lim);
		if (c >= lim) begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		tmo(i, 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_up();
		int i;
		for (i = 0; i < 600 && iop_reset_n !== 1'b1; i++)
			@(posedge pclk);
		tmo(i, 600);
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		cyc(16);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp("rails_off", 32'h0, {28'h0, rail_enable});
		apb(1'b0, 12'h000, 32'h0);
		cmp("ctrl", 32'h1, rd);
		apb(1'b1, 12'h000, 32'h3);
		cmp("array_sel", 32'h1, {31'h0, array_select});
		apb(1'b0, 12'h008, 32'h0);
		cmp("bad_resp", 32'h1, {31'h0, er});
		cmp("bad_data", 32'h0, rd);
		stby_on <= 1'b1;
		srv_on  <= 1'b1;
		iop_ok  <= 1'b1;
		wait_up();
		cmp("rails_up", 32'h1f, {27'h0, rail_enable, main_reset_n});
		apb(1'b0, 12'h004, 32'h0);
		cmp("status", 32'h3fe7, rd);
		srv_on <= 1'b0;
		cyc(6);
		cmp("srv_loss", 32'h0, {26'h0, rail_enable, main_reset_n, iop_reset_n});
		srv_on <= 1'b1;
		wait_up();
		audio_trigger <= 1'b1;
		for (n = 0; n < 40 && buzzer !== 1'b1; n++) @(posedge pclk);
		tmo(n, 40);
		for (n = 0; n < 40 && buzzer === 1'b1; n++) @(posedge pclk);
		tmo(n, 40);
		for (k = 0; k < 40 && buzzer !== 1'b1; k++) @(posedge pclk);
		tmo(k, 40);
		for (n = 0; n < 40 && buzzer === 1'b1; n++) @(posedge pclk);
		tmo(n, 40);
		cmp("buzz_low", BUZZ, k);
		cmp("buzz_high", BUZZ, n);
		audio_trigger <= 1'b0;
		cyc(6);
		cmp("buzz_idle", 32'h0, {31'h0, buzzer});
		cache_dirty <= 1'b1;
		cyc(5);
		cmp("backup", 32'h3, {30'h0, battery_backup_enable, battery_strobe});
		cyc(130);
		cmp("strobe_end", 32'h0, {31'h0, battery_strobe});
		for (k = 0; k < 2; k++) begin
			alarm_color_select <= k[0];
			critical_alarm <= 1'b1;
			major_alarm <= 1'b1;
			cyc(3);
			cmp("alarm", k ? 32'ha : 32'h5, {critical_red, critical_yellow, major_red, major_yellow});
		end
		drive_activity <= 3'h2;
		cyc(3);
		cmp("drv_act", 32'h2, {drive_led_green, drive_led_amber});
		drive_fault <= 3'h4;
		cyc(3);
		cmp("drv_fault", 32'h1, {drive_led_green, drive_led_amber});
		drive_present <= 3'h3;
		cyc(3);
		cmp("drv_absent", 32'h2, {drive_led_green, drive_led_amber});
		power_fail_delay <= 1'b1;
		iop_ok <= 1'b0;
		cyc(4);
		power_fail_done <= 1'b1;
		cyc(5);
		cmp("cke_hold", 32'h1, {31'h0, dimm_cke_hold});
		power_fail_delay <= 1'b0;
		power_fail_done <= 1'b0;
		iop_ok <= 1'b1;
		wait_up();
		cmp("cke_free", 32'h0, {31'h0, dimm_cke_hold});
		apb(1'b1, 12'h000, 32'h2);
		cyc(6);
		cmp("seq_off", 32'h0, {26'h0, rail_enable, main_reset_n, iop_reset_n});
		end_of_test();
	end
endmodule
